/* hw/smdm_merge.sv */
`timescale 1ns/100ps
`default_nettype none
module smdm_merge
(
	input  wire logic                     sys_clk,
	input  wire logic                     rst,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output var  logic [31:0]              hrdata,
	output var  logic                     hreadyout,
	output var  logic                     hresp,
	input  wire smdm_pkg::smdm_frame_type adc_in,
	input  wire logic [31:0]              dig_pins,
	input  wire logic                     option_fitted_pin,
	output var  smdm_pkg::smdm_frame_type sample_out,
	output var  logic                     irq
);
	import smdm_pkg::*;

	// ==========================================================
	// Bus address phase
	logic        acc;
	logic        wr_pend_q;
	logic [19:0] wr_idx_q;
	logic        wr_hit_q;
	logic [31:0] rd_val;

	smdm_mode_type              mode_q [8];
	logic [STATUS_W-1:0]        status_q;
	logic [STATUS_W-1:0]        mask_q;
	logic [15:0]                err_q;
	logic                       option_q;

	// Only full-word single transfers are expected, so hsize is ignored
	assign acc = hsel & htrans[1] & hready;

	// Latch write target for the data phase
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			wr_pend_q <= 1'b0;
			wr_idx_q  <= 20'h0;
			wr_hit_q  <= 1'b0;
		end
		else
		begin
			wr_pend_q <= acc & hwrite;
			wr_idx_q  <= haddr[21:2];
			wr_hit_q  <= (haddr[31:22] == 10'h0);
		end
	end

	// Read mux, evaluated in the address phase
	always_comb
	begin
		rd_val = 32'h0;
		if (haddr[31:22] == 10'h0)
		begin
			for (int i = 0; i < 8; i++)
				if (haddr[21:2] == MODE_IDX[i])
					rd_val = {30'h0, mode_q[i]};
			if (haddr[21:2] == STATUS_IDX)
				rd_val = {30'h0, status_q};
			if (haddr[21:2] == MASK_IDX)
				rd_val = {30'h0, mask_q};
			if (haddr[21:2] == ERROR_IDX)
				rd_val = {16'h0, err_q};
			if (haddr[21:2] == INFO_IDX)
				rd_val = {31'h0, option_q};
		end
	end

	// Zero-wait slave: data registered so it stands in the data phase
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			if (acc & ~hwrite)
				hrdata <= rd_val;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ==========================================================
	// Write checking
	logic       mode_wr;
	logic [2:0] wr_ch;
	logic       mode_ok;
	logic [15:0] rej_code;
	logic       sts_wr;
	logic       mask_wr;

	always_comb
	begin
		mode_wr  = 1'b0;
		wr_ch    = 3'h0;
		mode_ok  = 1'b0;
		rej_code = ERR_NONE;
		sts_wr   = 1'b0;
		mask_wr  = 1'b0;
		if (wr_pend_q)
		begin
			for (int i = 0; i < 8; i++)
				if (wr_hit_q && wr_idx_q == MODE_IDX[i])
				begin
					mode_wr = 1'b1;
					wr_ch   = 3'(i);
				end
			sts_wr  = wr_hit_q && wr_idx_q == STATUS_IDX;
			mask_wr = wr_hit_q && wr_idx_q == MASK_IDX;
			if (mode_wr)
			begin
				if (hwdata[31:2] != 30'h0)
					rej_code = ERR_BAD_VAL;
				else if (hwdata[1:0] != analog_only_code && !option_q)
					rej_code = ERR_NO_OPT;
				else if (hwdata[1:0] == full_input_substitute_code)
				begin
					// Only one substitute per four-channel module
					for (int j = 0; j < 8; j++)
						if (j[2] == wr_ch[2] && 3'(j) != wr_ch &&
							mode_q[j] == full_input_substitute_code)
							rej_code = ERR_BAD_VAL;
				end
				mode_ok = (rej_code == ERR_NONE);
			end
			else if (!sts_wr && !mask_wr)
				rej_code = ERR_BAD_REG;
		end
	end

	// Mode selectors
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < 8; i++)
				mode_q[i] <= MODE_RESET;
		end
		else if (mode_ok)
			mode_q[wr_ch] <= smdm_mode_type'(hwdata[1:0]);
	end

	// Last refusal code, kept until the next refusal
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			err_q <= ERR_NONE;
		else if (rej_code != ERR_NONE)
			err_q <= rej_code;
	end

	// ==========================================================
	// Interrupt status, mask and output
	logic [STATUS_W-1:0] ev;
	logic [STATUS_W-1:0] w1c;

	always_comb
	begin
		ev = '0;
		ev[ST_REJECT_BIT] = (rej_code != ERR_NONE);
		ev[ST_MODE_BIT]   = mode_ok;
		w1c = sts_wr ? hwdata[STATUS_W-1:0] : '0;
	end

	// Set wins over a same-cycle clear
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			status_q <= '0;
		else
			status_q <= (status_q & ~w1c) | ev;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			mask_q <= MASK_RESET;
		else if (mask_wr)
			mask_q <= hwdata[STATUS_W-1:0];
	end

	// Level interrupt, one cycle behind status
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(status_q & mask_q);
	end

	// ==========================================================
	// Pin synchronisers with agreement filter
	logic [32:0] pin_s1_q;
	logic [32:0] pin_s2_q;
	logic [32:0] pin_s3_q;
	logic [32:0] pin_q;
	logic [32:0] agree;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_s3_q <= '0;
		end
		else
		begin
			pin_s1_q <= {option_fitted_pin, dig_pins};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// A bit moves only when stages two and three agree
	assign agree = ~(pin_s2_q ^ pin_s3_q);

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			pin_q <= '0;
		else
			pin_q <= (pin_s3_q & agree) | (pin_q & ~agree);
	end

	assign option_q = pin_q[32];

	// ==========================================================
	// Analog delay matching the pin path
	smdm_frame_type adc_pipe_q [ALIGN_STAGES];

	// Keeps digital and analog of one edge together
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			for (int s = 0; s < ALIGN_STAGES; s++)
				adc_pipe_q[s] <= '0;
		end
		else
		begin
			adc_pipe_q[0] <= adc_in;
			for (int s = 1; s < ALIGN_STAGES; s++)
				adc_pipe_q[s] <= adc_pipe_q[s-1];
		end
	end

	// ==========================================================
	// Word composition
	function automatic logic [15:0] compose(
		input smdm_mode_type mode,
		input logic [15:0]   adc,
		input logic [31:0]   dig,
		input int            ch
	);
		logic [3:0] nib;
		nib = dig[4*ch +: 4];
		compose = adc;
		unique case (mode)
			analog_only_code:
				compose = adc;
			two_input_merge_code:
				compose = {nib[1:0], adc[15:2]};
			four_input_merge_code:
				compose = {nib, adc[15:4]};
			full_input_substitute_code:
				// Second module takes the upper half
				compose = (ch >= 4) ? dig[31:16] : dig[15:0];
		endcase
	endfunction

	// Option missing forces analog-only regardless of stored code
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			sample_out <= '0;
		else
		begin
			sample_out.valid <= adc_pipe_q[ALIGN_STAGES-1].valid;
			for (int c = 0; c < 8; c++)
				sample_out.word[c] <= compose(
					option_q ? mode_q[c] : analog_only_code,
					adc_pipe_q[ALIGN_STAGES-1].word[c],
					pin_q[31:0], c);
		end
	end

endmodule
`default_nettype wire

/* shared/smdm_pkg.sv */
// Contract
// - Each of eight channels has a read/write mode selector for codes 0 to 3.
// - Code 0 adds no digital bits; the word is converter bits 15..0 unchanged.
// - Code 1: digital bits 1,0 in word 15,14, converter bits 15..2 below.
// - Code 2: digital bits 3..0 in word 15..12, converter bits 15..4 below.
// - Code 3 drops the analog sample; digital bit n goes to word bit n.
// - A replaced channel among channels 4..7 takes digital inputs 31..16.
// - Analog samples are twos complement, -32768 to +32767 at full width.
// - Codes other than 0 are accepted only with the digital option fitted.
// - Refusals report 100h bad register, 101h bad value, 102h no option.
// - Digital inputs join the analog sample taken on the same edge.
// - At most one of channels 0..3 and one of 4..7 may be fully replaced.
// - Reduced modes of channel x use inputs 4x..4x+3 or 4x..4x+1.
`default_nettype none
package smdm_pkg;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [19:0] MODE_IDX [8] = '{
		20'h1ae78, 20'h1ae79, 20'h1ae7a, 20'h1ae7b,
		20'h1ae7c, 20'h1ae7d, 20'h1ae7e, 20'h1ae7f
	};
	localparam logic [19:0] STATUS_IDX = 20'h1ae80;
	localparam logic [19:0] MASK_IDX   = 20'h1ae81;
	localparam logic [19:0] ERROR_IDX  = 20'h1ae82;
	localparam logic [19:0] INFO_IDX   = 20'h1ae83;

	// ==========================================================
	// Mode codes
	typedef enum logic [1:0] {
		analog_only_code          = 2'h0,
		two_input_merge_code      = 2'h1,
		four_input_merge_code     = 2'h2,
		full_input_substitute_code = 2'h3
	} smdm_mode_type;

	// ==========================================================
	// Refusal codes and field layout
	localparam logic [15:0] ERR_NONE    = 16'h0000;
	localparam logic [15:0] ERR_BAD_REG = 16'h0100;
	localparam logic [15:0] ERR_BAD_VAL = 16'h0101;
	localparam logic [15:0] ERR_NO_OPT  = 16'h0102;
	localparam int          ST_REJECT_BIT = 0;
	localparam int          ST_MODE_BIT   = 1;
	localparam int          STATUS_W      = 2;
	localparam int          INFO_OPT_BIT  = 0;
	localparam logic [STATUS_W-1:0] MASK_RESET = 2'h0;
	localparam smdm_mode_type MODE_RESET = analog_only_code;

	// ==========================================================
	// Timing: pin synchroniser depth and matching analog delay
	localparam int ALIGN_STAGES = 4;

	// ==========================================================
	// Sample frame carrier: one 16-bit word per channel
	typedef struct packed {
		logic             valid;
		logic [7:0][15:0] word;
	} smdm_frame_type;

endpackage
`default_nettype wire

/* dv/smdm_merge_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========
// Port checker for the merge block
module smdm_merge_chk
(
	input wire logic                     sys_clk,
	input wire logic                     rst,
	input wire logic                     hsel,
	input wire logic [31:0]              haddr,
	input wire logic [1:0]               htrans,
	input wire logic                     hwrite,
	input wire logic                     hready,
	input wire logic [31:0]              hrdata,
	input wire logic                     hreadyout,
	input wire logic                     hresp,
	input wire smdm_pkg::smdm_frame_type adc_in,
	input wire logic                     option_fitted_pin,
	input wire smdm_pkg::smdm_frame_type sample_out,
	input wire logic                     irq
);
	import smdm_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Bus answers, sample timing and word content
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	chk_ready_high: assert property (hreadyout == 1'b1)
		else $error("slave inserted wait state");
	chk_valid_delay: assert property (
		adc_in.valid |-> ##5 sample_out.valid)
		else $error("sample missing after five edges");
	chk_valid_only: assert property (
		sample_out.valid |-> $past(adc_in.valid, 5))
		else $error("sample without a cause");
	chk_reset_quiet: assert property (
		disable iff (1'b0) rst |=> !irq && !sample_out.valid)
		else $error("outputs active after reset");
	chk_noopt_analog: assert property (
		!option_fitted_pin [*8] ##0 adc_in.valid
		|-> ##5 sample_out.word == $past(adc_in.word, 5))
		else $error("digital merge without option");
	chk_irq_from_write: assert property (
		$rose(irq) |-> $past(hsel && htrans[1] && hwrite, 3))
		else $error("interrupt without a write");
	chk_unmapped_zero: assert property (
		hsel && htrans[1] && hready && !hwrite
		&& haddr[31:22] != 10'h0 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
endmodule
bind smdm_merge smdm_merge_chk i_chk (.sys_clk, .rst, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hrdata, .hreadyout, .hresp, .adc_in, .option_fitted_pin,
	.sample_out, .irq);
`default_nettype wire

/* dv/smdm_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========
// Converters and digital lines feeding the block
module smdm_far_model
(
	input  wire logic                     sys_clk,
	output var  smdm_pkg::smdm_frame_type adc_in,
	output var  logic [31:0]              dig_pins
);
	import smdm_pkg::*;
	// Quiet at time zero
	initial
	begin
		adc_in = '0;
		dig_pins = 32'h0;
	end
	// One twos complement sample, pins held over the filter span
	task send(input logic [7:0][15:0] w, input logic [31:0] d);
		adc_in <= '{valid: 1'b1, word: w};
		dig_pins <= d;
		@(posedge sys_clk);
		adc_in.valid <= 1'b0;
		repeat (2) @(posedge sys_clk);
		dig_pins <= ~d; // Pins move on, never linger
	endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========
// Bench top
module tb;
	import smdm_pkg::*;
	logic                sys_clk = 1'b0;
	logic                rst = 1'b1;
	logic                hsel = 1'b1;
	logic [31:0]         haddr = 32'h0;
	logic [1:0]          htrans = 2'h0;
	logic                hwrite = 1'b0;
	logic [2:0]          hsize = 3'h2;
	logic [31:0]         hwdata = 32'h0;
	logic                option_fitted_pin = 1'b0;
	wire logic           hready;
	logic [31:0]         hrdata, dig_pins, rd, seed = 32'd94378;
	logic                hreadyout, hresp, irq;
	smdm_frame_type      adc_in, sample_out;
	logic [1:0]          m [8];
	int                  bad_count = 0, check_count = 0, s;
	smdm_merge i_dut (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .adc_in, .dig_pins,
		.option_fitted_pin, .sample_out, .irq);
	smdm_far_model i_far (.sys_clk, .adc_in, .dig_pins);
	assign hready = hreadyout;
	// Clock
	always #5 sys_clk = ~sys_clk;
	// ==========
	// Helpers
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function logic [31:0] ad(logic [19:0] i);
		return {10'h0, i, 2'h0};
	endfunction
	function logic [15:0] ew(logic [1:0] md, logic [15:0] a,
		logic [31:0] d, int c);
		case (md)
			2'h0: return a;
			2'h1: return {d[4*c+1], d[4*c], a[15:2]};
			2'h2: return {d[4*c+3 -: 4], a[15:4]};
			default: return (c < 4) ? d[15:0] : d[31:16];
		endcase
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Single word transfer: address phase, then data phase
	task bus(input logic [31:0] a, input logic [31:0] d, input logic w);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge sys_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task rchk(input logic [31:0] a, input logic [31:0] e);
		bus(a, 32'h0, 1'b0);
		chk(rd, e);
	endtask
	// One frame through the far side, all eight words compared
	task smp(input logic [15:0] a0, input logic opt);
		logic [7:0][15:0] w;
		logic [31:0]      d;
		w = {rnd(), rnd(), rnd(), rnd()};
		w[0] = a0;
		d = rnd();
		i_far.send(w, d);
		do @(posedge sys_clk); while (sample_out.valid !== 1'b1);
		for (int c = 0; c < 8; c++)
			chk(sample_out.word[c], opt ? ew(m[c], w[c], d, c) : w[c]);
		repeat (rnd() % 3) @(posedge sys_clk);
	endtask
	task summarize;
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		summarize;
	end
	// ==========
	// Main sequence
	initial
	begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		for (int c = 0; c < 8; c++)
		begin
			m[c] = 2'h0;
			rchk(ad(MODE_IDX[c]), 32'h0);
		end
		rchk(32'hffc0_0000, 32'h0);
		smp(16'h8000, 1'b0);
		bus(ad(MODE_IDX[0]), 32'h1, 1'b1);
		rchk(ad(ERROR_IDX), ERR_NO_OPT);
		rchk(ad(MODE_IDX[0]), 32'h0);
		option_fitted_pin <= 1'b1;
		repeat (8) @(posedge sys_clk);
		rchk(ad(INFO_IDX), 32'h1);
		bus(ad(MODE_IDX[1]), 32'h5, 1'b1);
		rchk(ad(ERROR_IDX), ERR_BAD_VAL);
		bus(ad(INFO_IDX), 32'h1, 1'b1);
		rchk(ad(ERROR_IDX), ERR_BAD_REG);
		bus(ad(MASK_IDX), 32'h1, 1'b1);
		repeat (2) @(posedge sys_clk);
		chk(irq, 32'h1);
		// Refusals so far set only the reject bit
		rchk(ad(MASK_IDX), 32'h1);
		rchk(ad(STATUS_IDX), 32'h1);
		bus(ad(STATUS_IDX), 32'h1, 1'b1);
		repeat (2) @(posedge sys_clk);
		chk(irq, 32'h0);
		repeat (3)
		begin
			// Non-replacing codes first so the single substitute fits
			for (int g = 0; g < 2; g++)
			begin
				s = rnd() % 4;
				for (int i = 0; i < 4; i++)
				begin
					m[4*g+i] = 2'(rnd() % 3);
					bus(ad(MODE_IDX[4*g+i]), {30'h0, m[4*g+i]}, 1'b1);
				end
				m[4*g+s] = 2'h3;
				bus(ad(MODE_IDX[4*g+s]), 32'h3, 1'b1);
			end
			for (int c = 0; c < 8; c++)
				rchk(ad(MODE_IDX[c]), {30'h0, m[c]});
			chk(irq, 32'h0);
			// Accepted writes only, so just the accepted bit stands
			rchk(ad(STATUS_IDX), 32'h2);
			bus(ad(MODE_IDX[4+(s+1)%4]), 32'h3, 1'b1);
			rchk(ad(ERROR_IDX), ERR_BAD_VAL);
			rchk(ad(MODE_IDX[4+(s+1)%4]), {30'h0, m[4+(s+1)%4]});
			bus(ad(STATUS_IDX), 32'h3, 1'b1);
			smp(16'h7fff, 1'b1);
			smp(16'h8000, 1'b1);
			repeat (6) smp(16'(rnd()), 1'b1);
		end
		summarize;
	end
endmodule
`default_nettype wire
